// ===== src/fpu_control_status_cfg.svh
`ifndef FPU_CONTROL_STATUS_CFG_SVH
`define FPU_CONTROL_STATUS_CFG_SVH

// ****************************************
// Coprocessor register numbers
// ****************************************
`define FPU_CONTROL_STATUS_REG_MODE_VIEW 5'h1c
`define FPU_CONTROL_STATUS_REG_FULL 5'h1f

// ****************************************
// Field positions, full word
// ****************************************
`define FPU_CONTROL_STATUS_CC_HI_MSB 31
`define FPU_CONTROL_STATUS_CC_HI_LSB 25
`define FPU_CONTROL_STATUS_FLUSH_BIT 24
`define FPU_CONTROL_STATUS_CC_LO_BIT 23
`define FPU_CONTROL_STATUS_OVR_BIT 22
`define FPU_CONTROL_STATUS_NEAR_BIT 21
`define FPU_CONTROL_STATUS_MADD_BIT 20
`define FPU_CONTROL_STATUS_ABSNEG_BIT 19
`define FPU_CONTROL_STATUS_NAN_BIT 18
`define FPU_CONTROL_STATUS_CAUSE_MSB 17
`define FPU_CONTROL_STATUS_CAUSE_LSB 12
`define FPU_CONTROL_STATUS_EN_MSB 11
`define FPU_CONTROL_STATUS_EN_LSB 7
`define FPU_CONTROL_STATUS_FLAG_MSB 6
`define FPU_CONTROL_STATUS_FLAG_LSB 2
`define FPU_CONTROL_STATUS_RM_MSB 1
`define FPU_CONTROL_STATUS_RM_LSB 0

// ****************************************
// Field positions, reduced view
// ****************************************
`define FPU_CONTROL_STATUS_VIEW_FLUSH_BIT 2

// ****************************************
// Fixed values and reset values
// ****************************************
`define FPU_CONTROL_STATUS_MADD_VAL 1'b0
`define FPU_CONTROL_STATUS_ABSNEG_VAL 1'b1
`define FPU_CONTROL_STATUS_NAN_VAL 1'b1
`define FPU_CONTROL_STATUS_RST_CC 8'h00
`define FPU_CONTROL_STATUS_RST_CAUSE 6'h00
`define FPU_CONTROL_STATUS_RST_EN 5'h00
`define FPU_CONTROL_STATUS_RST_FLAG 5'h00
`define FPU_CONTROL_STATUS_RST_RM 2'h0

`endif

// ===== src/fpu_control_status_pkg.sv
`default_nettype none

package fpu_control_status_pkg;

    // Rounding selector values
    typedef enum logic [1:0] {
        FPU_CONTROL_STATUS_RND_NEAREST = 2'h0,
        FPU_CONTROL_STATUS_RND_ZERO = 2'h1,
        FPU_CONTROL_STATUS_RND_PLUS = 2'h2,
        FPU_CONTROL_STATUS_RND_MINUS = 2'h3
    } fpu_control_status_round_e;

    // Five IEEE exception classes, invalid first
    typedef struct packed {
        logic invalid;
        logic divZero;
        logic overflow;
        logic underflow;
        logic inexact;
    } fpu_control_status_exc_s;

    // Report of one finished arithmetic instruction
    typedef struct packed {
        logic valid;
        logic unimpl;
        fpu_control_status_exc_s exc;
    } fpu_control_status_result_s;

    // Register move from the core
    typedef struct packed {
        logic wrEn;
        logic [4:0] regNum;
        logic [31:0] data;
    } fpu_control_status_move_s;

    // Controls handed to the arithmetic datapath
    typedef struct packed {
        logic flushZero;
        logic flushOverride;
        logic flushNearest;
        fpu_control_status_round_e round;
    } fpu_control_status_mode_s;

endpackage : fpu_control_status_pkg

`default_nettype wire

// ===== src/fpu_control_status_trap_check.sv
`default_nettype none

`include "fpu_control_status_cfg.svh"

module fpu_control_status_trap_check
    import fpu_control_status_pkg::*;
(
    // Stored cause and enable bits
    input wire logic [5:0] cause,
    input wire logic [4:0] trap_mask_bits,
    // Trap request toward the core
    output logic trapReq,
    output logic [5:0] trapCause
);

    // Unimplemented-operation cause always traps; others need their enable
    always_comb begin
        trapCause = {cause[5], cause[4:0] & trap_mask_bits};
        trapReq = |trapCause;
    end

endmodule : fpu_control_status_trap_check

`default_nettype wire

// ===== src/fpu_control_status_denorm_check.sv
`default_nettype none

`include "fpu_control_status_cfg.svh"

module fpu_control_status_denorm_check
    import fpu_control_status_pkg::*;
(
    // Operand class flags from the datapath
    input wire logic denormIn,
    // Active mode
    input wire fpu_control_status_mode_s mode,
    // Decisions
    output logic zeroInput,
    output logic unimplExc,
    output logic tinyToZero,
    output logic tinyNearest
);

    // Denormal handling and tiny-result policy
    always_comb begin
        zeroInput = denormIn && mode.flushZero;
        unimplExc = denormIn && !mode.flushZero;
        // Override keeps unlimited exponent and suppresses both tiny-result forcings; zeroInput still follows flushZero
        tinyNearest = !mode.flushOverride && mode.flushNearest
            && (mode.round == FPU_CONTROL_STATUS_RND_NEAREST);
        tinyToZero = !mode.flushOverride && !tinyNearest
            && (mode.flushZero || mode.flushNearest);
    end

endmodule : fpu_control_status_denorm_check

`default_nettype wire

// ===== src/fpu_control_status_regs.sv

`default_nettype none

`include "fpu_control_status_cfg.svh"

module fpu_control_status_regs
    import fpu_control_status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register moves from the core
    input wire fpu_control_status_move_s move,
    input wire logic [4:0] rdRegNum,
    output logic [31:0] rdData,
    // Compare results
    input wire logic cmpValid,
    input wire logic [2:0] cmpIndex,
    input wire logic cmpResult,
    input wire logic [2:0] testIndex,
    output logic condTrue,
    // Arithmetic results
    input wire fpu_control_status_result_s result,
    input wire logic denormIn,
    // Mode toward the datapath
    output fpu_control_status_mode_s mode,
    output logic zeroInput,
    output logic unimplExc,
    output logic tinyToZero,
    output logic tinyNearest,
    output logic nanQuietMsb,
    // Trap toward the core
    output logic trapReq,
    output logic [5:0] trapCause
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] cc_q;  // Compare result bits
    logic flush_q;  // Flush to zero
    logic ovr_q;  // Flush override
    logic near_q;  // Flush to nearest
    logic [5:0] cause_q;  // Cause, bit 5 is unimplemented op
    logic [4:0] en_q;  // Trap trap_mask_bits
    logic [4:0] flag_q;  // Sticky flags
    logic [1:0] rm_q;  // Rounding selector
    logic wrFull;
    logic wrView;
    logic [31:0] rdData_d;  // Read word chosen this cycle
    logic [31:0] rdData_q;  // Read word held for the core

    // Write decode for the two views
    always_comb begin
        wrFull = move.wrEn && (move.regNum == `FPU_CONTROL_STATUS_REG_FULL);
        wrView = move.wrEn && (move.regNum == `FPU_CONTROL_STATUS_REG_MODE_VIEW);
    end

    // Compare bits: hardware compare wins over a software move
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cc_q <= `FPU_CONTROL_STATUS_RST_CC;
        end else begin
            if (wrFull) begin
                cc_q <= {move.data[`FPU_CONTROL_STATUS_CC_HI_MSB:`FPU_CONTROL_STATUS_CC_HI_LSB], move.data[`FPU_CONTROL_STATUS_CC_LO_BIT]};
            end
            if (cmpValid) begin
                cc_q[cmpIndex] <= cmpResult;
            end
        end
    end

    // Branch and conditional-move test
    always_comb begin
        condTrue = cc_q[testIndex];
    end

    // Trap_mask_bits, flush and rounding: both views hit the same bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= `FPU_CONTROL_STATUS_RST_EN;
            flush_q <= 1'b0;
            rm_q <= `FPU_CONTROL_STATUS_RST_RM;
        end else if (wrFull) begin
            en_q <= move.data[`FPU_CONTROL_STATUS_EN_MSB:`FPU_CONTROL_STATUS_EN_LSB];
            flush_q <= move.data[`FPU_CONTROL_STATUS_FLUSH_BIT];
            rm_q <= move.data[`FPU_CONTROL_STATUS_RM_MSB:`FPU_CONTROL_STATUS_RM_LSB];
        end else if (wrView) begin
            en_q <= move.data[`FPU_CONTROL_STATUS_EN_MSB:`FPU_CONTROL_STATUS_EN_LSB];
            flush_q <= move.data[`FPU_CONTROL_STATUS_VIEW_FLUSH_BIT];
            rm_q <= move.data[`FPU_CONTROL_STATUS_RM_MSB:`FPU_CONTROL_STATUS_RM_LSB];
        end
    end

    // Override and nearest controls exist only in the full word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovr_q <= 1'b0;
            near_q <= 1'b0;
        end else if (wrFull) begin
            ovr_q <= move.data[`FPU_CONTROL_STATUS_OVR_BIT];
            near_q <= move.data[`FPU_CONTROL_STATUS_NEAR_BIT];
        end
    end

    // Cause: replaced by each instruction; a same-cycle result beats the move
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_q <= `FPU_CONTROL_STATUS_RST_CAUSE;
        end else if (result.valid) begin
            cause_q <= {result.unimpl, result.exc};
        end else if (wrFull) begin
            cause_q <= move.data[`FPU_CONTROL_STATUS_CAUSE_MSB:`FPU_CONTROL_STATUS_CAUSE_LSB];
        end
    end

    // Sticky flags: set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q <= `FPU_CONTROL_STATUS_RST_FLAG;
        end else begin
            flag_q <= (wrFull ? move.data[`FPU_CONTROL_STATUS_FLAG_MSB:`FPU_CONTROL_STATUS_FLAG_LSB] : flag_q)
                | (result.valid ? result.exc : 5'h00);
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdData_d = 32'h0000_0000;
        if (rdRegNum == `FPU_CONTROL_STATUS_REG_FULL) begin
            rdData_d[`FPU_CONTROL_STATUS_CC_HI_MSB:`FPU_CONTROL_STATUS_CC_HI_LSB] = cc_q[7:1];
            rdData_d[`FPU_CONTROL_STATUS_FLUSH_BIT] = flush_q;
            rdData_d[`FPU_CONTROL_STATUS_CC_LO_BIT] = cc_q[0];
            rdData_d[`FPU_CONTROL_STATUS_OVR_BIT] = ovr_q;
            rdData_d[`FPU_CONTROL_STATUS_NEAR_BIT] = near_q;
            rdData_d[`FPU_CONTROL_STATUS_MADD_BIT] = `FPU_CONTROL_STATUS_MADD_VAL;
            rdData_d[`FPU_CONTROL_STATUS_ABSNEG_BIT] = `FPU_CONTROL_STATUS_ABSNEG_VAL;
            rdData_d[`FPU_CONTROL_STATUS_NAN_BIT] = `FPU_CONTROL_STATUS_NAN_VAL;
            rdData_d[`FPU_CONTROL_STATUS_CAUSE_MSB:`FPU_CONTROL_STATUS_CAUSE_LSB] = cause_q;
            rdData_d[`FPU_CONTROL_STATUS_EN_MSB:`FPU_CONTROL_STATUS_EN_LSB] = en_q;
            rdData_d[`FPU_CONTROL_STATUS_FLAG_MSB:`FPU_CONTROL_STATUS_FLAG_LSB] = flag_q;
            rdData_d[`FPU_CONTROL_STATUS_RM_MSB:`FPU_CONTROL_STATUS_RM_LSB] = rm_q;
        end else if (rdRegNum == `FPU_CONTROL_STATUS_REG_MODE_VIEW) begin
            // Bits 31..12 and 6..3 stay zero
            rdData_d[`FPU_CONTROL_STATUS_EN_MSB:`FPU_CONTROL_STATUS_EN_LSB] = en_q;
            rdData_d[`FPU_CONTROL_STATUS_VIEW_FLUSH_BIT] = flush_q;
            rdData_d[`FPU_CONTROL_STATUS_RM_MSB:`FPU_CONTROL_STATUS_RM_LSB] = rm_q;
        end
    end

    // Read word is registered so the core sees a steady value;
    // it trails the register select by one clock, and a write in
    // that same clock only shows on the following read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= 32'h0000_0000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Port driven straight from the flop
    always_comb begin
        rdData = rdData_q;
    end

    // Mode out; NaN quiet bit polarity is fixed at one
    always_comb begin
        mode.flushZero = flush_q;
        mode.flushOverride = ovr_q;
        mode.flushNearest = near_q;
        mode.round = fpu_control_status_round_e'(rm_q);
        nanQuietMsb = `FPU_CONTROL_STATUS_NAN_VAL;
    end

    // ****************************************
    // Submodules
    // ****************************************
    fpu_control_status_trap_check u_trap (
        .cause(cause_q),
        .trap_mask_bits(en_q),
        .trapReq(trapReq),
        .trapCause(trapCause)
    );

    fpu_control_status_denorm_check u_denorm (
        .denormIn(denormIn),
        .mode(mode),
        .zeroInput(zeroInput),
        .unimplExc(unimplExc),
        .tinyToZero(tinyToZero),
        .tinyNearest(tinyNearest)
    );

    // ****************************************
    // Checks
    // ****************************************
    // A write through the reduced view alone
    sequence s_viewWrite;
        wrView && !wrFull;
    endsequence

    // A full-word write with no instruction finishing beside it
    sequence s_fullWriteQuiet;
        wrFull && !result.valid;
    endsequence

    // Flush to nearest live while round to nearest is selected
    sequence s_nearestRound;
        near_q && !ovr_q && (rm_q == 2'h0);
    endsequence

    // Read side: the registered word trails the select by one edge
    a_view_high_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (rdRegNum == `FPU_CONTROL_STATUS_REG_MODE_VIEW) |=> (rdData[31:12] == 20'h00000))
        else $error("view high bits not zero");
    a_view_mid_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (rdRegNum == `FPU_CONTROL_STATUS_REG_MODE_VIEW) |=> (rdData[6:3] == 4'h0))
        else $error("view mid bits not zero");
    a_view_low_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (rdRegNum == `FPU_CONTROL_STATUS_REG_MODE_VIEW) |=> (rdData[11:7] == $past(en_q)) && (rdData[2] == $past(flush_q)))
        else $error("view low bits wrong");
    a_fixed_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (rdRegNum == `FPU_CONTROL_STATUS_REG_FULL) |=> (rdData[20:18] == 3'h3))
        else $error("fixed bits wrong");

    // Storage: what a write or a result leaves behind
    a_enable_stored: assert property (@(posedge clk) disable iff (sys_rst)
        wrFull |=> (en_q == $past(move.data[11:7])))
        else $error("trap_mask_bits not stored");
    a_view_shares: assert property (@(posedge clk) disable iff (sys_rst)
        s_viewWrite |=> (flush_q == $past(move.data[2])) && (rm_q == $past(move.data[1:0])))
        else $error("view write not shared");
    a_view_keeps_override: assert property (@(posedge clk) disable iff (sys_rst)
        s_viewWrite |=> (ovr_q == $past(ovr_q)) && (near_q == $past(near_q)))
        else $error("view write touched full-only bits");
    a_cc_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wrFull && !cmpValid) |=> (cc_q == $past({move.data[31:25], move.data[23]})))
        else $error("compare bits not written");
    a_compare_cc: assert property (@(posedge clk) disable iff (sys_rst)
        cmpValid |=> (cc_q[$past(cmpIndex)] == $past(cmpResult)))
        else $error("compare bit wrong");
    a_cause_latch: assert property (@(posedge clk) disable iff (sys_rst)
        result.valid |=> (cause_q == $past({result.unimpl, result.exc})))
        else $error("cause not latched");
    a_cause_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_fullWriteQuiet |=> (cause_q == $past(move.data[17:12])))
        else $error("cause not written");
    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (result.valid && result.exc.invalid) |=> flag_q[4])
        else $error("flag not set");
    a_flag_accum: assert property (@(posedge clk) disable iff (sys_rst)
        result.valid |=> ((flag_q & $past(result.exc)) == $past(result.exc)))
        else $error("flags not accumulated");
    a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
        s_fullWriteQuiet |=> (flag_q == $past(move.data[6:2])))
        else $error("flags not written");
    a_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (!wrFull && !result.valid) |=> (flag_q == $past(flag_q)))
        else $error("flags changed unasked");

    // Trap request toward the core
    a_trap_on_enable: assert property (@(posedge clk) disable iff (sys_rst)
        (|(cause_q[4:0] & en_q)) |-> trapReq)
        else $error("trap missing");
    a_no_trap: assert property (@(posedge clk) disable iff (sys_rst)
        (!cause_q[5] && ((cause_q[4:0] & en_q) == 5'h00)) |-> !trapReq)
        else $error("trap without cause");
    a_unimpl_trap: assert property (@(posedge clk) disable iff (sys_rst)
        cause_q[5] |-> trapReq)
        else $error("unimplemented op did not trap");
    a_trap_cause: assert property (@(posedge clk) disable iff (sys_rst)
        trapReq |-> (trapCause[4:0] == (cause_q[4:0] & en_q)) && (trapCause[5] == cause_q[5]))
        else $error("trap cause wrong");

    // Mode decisions toward the datapath
    a_flush_denorm: assert property (@(posedge clk) disable iff (sys_rst)
        denormIn |-> (zeroInput == flush_q) && (unimplExc == !flush_q))
        else $error("denormal handling wrong");
    a_override_free: assert property (@(posedge clk) disable iff (sys_rst)
        mode.flushOverride |-> (!tinyToZero && !tinyNearest))
        else $error("override still forces");
    a_nearest_rn: assert property (@(posedge clk) disable iff (sys_rst)
        s_nearestRound |-> (tinyNearest && !tinyToZero))
        else $error("nearest flush not chosen");
    a_nearest_other: assert property (@(posedge clk) disable iff (sys_rst)
        (near_q && !ovr_q && (rm_q != 2'h0)) |-> (tinyToZero && !tinyNearest))
        else $error("nearest flush not as zero flush");

endmodule : fpu_control_status_regs

`default_nettype wire

// ===== dv/fpu_control_status_regs_test.sv
`default_nettype none

`include "fpu_control_status_cfg.svh"

module fpu_control_status_regs_test import fpu_control_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk = 1'b0; // 10 MHz core clock
    logic sysRst = 1'b1; // Synchronous reset, high
    fpu_control_status_move_s move = '0;
    logic [4:0] rdRegNum = 5'h00;
    logic [31:0] rdData;
    logic cmpValid = 1'b0;
    logic [2:0] cmpIndex = 3'h0;
    logic cmpResult = 1'b0;
    logic [2:0] testIndex = 3'h0;
    logic condTrue;
    fpu_control_status_result_s result = '0;
    logic denormIn = 1'b0;
    fpu_control_status_mode_s mode;
    logic zeroInput, unimplExc, tinyToZero, tinyNearest, nanQuietMsb, trapReq;
    logic [5:0] trapCause;
    int numErrors = 0; // Mismatches seen
    int samplesChecked = 0; // Comparisons made
    logic [7:0] ccExp; // Expected compare bits

    // Half period of 50 ns
    always #50 clk = ~clk;

    fpu_control_status_regs u_dut (.clk(clk), .sys_rst(sysRst), .move(move), .rdRegNum(rdRegNum), .rdData(rdData),
        .cmpValid(cmpValid), .cmpIndex(cmpIndex), .cmpResult(cmpResult), .testIndex(testIndex),
        .condTrue(condTrue), .result(result), .denormIn(denormIn), .mode(mode), .zeroInput(zeroInput),
        .unimplExc(unimplExc), .tinyToZero(tinyToZero), .tinyNearest(tinyNearest),
        .nanQuietMsb(nanQuietMsb), .trapReq(trapReq), .trapCause(trapCause));

    // ****************************************
    // Shared tasks
    // ****************************************
    // Compare one value; case inequality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One register move; starts on the next falling edge so that
    // a strobe lowered by the previous call never rises in the same step
    task automatic wr(input logic [4:0] num, input logic [31:0] dat);
        @(negedge clk);
        move = '{wrEn: 1'b1, regNum: num, data: dat};
        @(negedge clk);
        move.wrEn = 1'b0;
    endtask : wr

    // Read word is registered: name the register, look one edge later
    task automatic rdChk(input logic [4:0] num, input logic [31:0] exp, input string what);
        @(negedge clk);
        rdRegNum = num;
        @(negedge clk);
        chk(rdData, exp, what);
    endtask : rdChk

    // One finished arithmetic instruction, single-cycle valid
    task automatic fin(input logic [4:0] exc, input logic unimp);
        @(negedge clk);
        result = {1'b1, unimp, exc};
        @(negedge clk);
        result.valid = 1'b0;
    endtask : fin

    // ****************************************
    // Scenarios
    // ****************************************
    // Full word with every bit written: fixed bits hold, view masks
    task automatic tWide();
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c0000, "reset full");
        chk(nanQuietMsb, 1'b1, "nan msb");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'hffffffff);
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'hffefffff, "full ones");
        rdChk(`FPU_CONTROL_STATUS_REG_MODE_VIEW, 32'h00000f87, "view of full");
        rdChk(5'h00, 32'h0, "unmapped");
        chk(trapCause, 6'h3f, "all cause");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h0);
        wr(`FPU_CONTROL_STATUS_REG_MODE_VIEW, 32'hffffffff);
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h010c0f83, "full of view");
    endtask : tWide

    // Every rounding code, decoded toward the datapath
    task automatic tRound();
        fpu_control_status_round_e rnd [4] = '{FPU_CONTROL_STATUS_RND_NEAREST, FPU_CONTROL_STATUS_RND_ZERO, FPU_CONTROL_STATUS_RND_PLUS, FPU_CONTROL_STATUS_RND_MINUS};
        for (int i = 0; i < 4; i++) begin
            wr(`FPU_CONTROL_STATUS_REG_MODE_VIEW, 32'(i));
            chk(mode.round, rnd[i], "round");
            rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c0000 | 32'(i), "round full");
        end
    endtask : tRound

    // Each class traps only with its own enable
    task automatic tTrap();
        for (int i = 0; i < 5; i++) begin
            wr(`FPU_CONTROL_STATUS_REG_FULL, (32'h1000 << i) | (32'h80 << i));
            chk(trapReq, 1'b1, "trap hit");
            chk(trapCause, 6'h1 << i, "trap cause");
            wr(`FPU_CONTROL_STATUS_REG_FULL, (32'h1000 << i) | (32'h80 << ((i + 1) % 5)));
            chk(trapReq, 1'b0, "trap miss");
        end
    endtask : tTrap

    // Cause follows the last result, flags pile up until cleared
    task automatic tResult();
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h0);
        fin(5'h10, 1'b0);
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000d0040, "invalid");
        fin(5'h01, 1'b0);
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c1044, "inexact");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h80);
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c0080, "flags cleared");
        fin(5'h01, 1'b0);
        chk(trapReq, 1'b1, "arith trap");
        chk(trapCause, 6'h01, "arith cause");
        fin(5'h00, 1'b1);
        chk(trapCause, 6'h20, "unimpl cause");
    endtask : tResult

    // Each compare bit lands in place and feeds the condition test
    task automatic tCompare();
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h0);
        ccExp = 8'h00;
        for (int i = 0; i < 9; i++) begin
            cmpIndex = (i == 8) ? 3'h3 : 3'(i);
            cmpResult = (i != 8);
            cmpValid = 1'b1;
            ccExp[cmpIndex] = cmpResult;
            @(negedge clk);
            cmpValid = 1'b0;
            testIndex = cmpIndex;
            #1;
            chk(condTrue, cmpResult, "cond");
            rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c0000 | {ccExp[7:1], 25'h0} | {8'h0, ccExp[0], 23'h0}, "cc");
        end
    endtask : tCompare

    // Denormal and tiny-result decisions under each flush control
    task automatic tDenorm();
        denormIn = 1'b1;
        wr(`FPU_CONTROL_STATUS_REG_MODE_VIEW, 32'h4);
        chk({zeroInput, unimplExc, tinyToZero}, 3'b101, "flush on");
        chk(mode, 5'h10, "mode flush");
        wr(`FPU_CONTROL_STATUS_REG_MODE_VIEW, 32'h0);
        chk({zeroInput, unimplExc}, 2'b01, "flush off");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h01400000);
        chk({mode.flushOverride, tinyToZero, tinyNearest}, 3'b100, "override");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h00200000);
        chk({tinyNearest, tinyToZero}, 2'b10, "nearest rn");
        chk(mode, 5'h04, "mode nearest");
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'h00200001);
        chk({tinyNearest, tinyToZero}, 2'b01, "nearest rz");
        denormIn = 1'b0;
    endtask : tDenorm

    // Reset in mid-run clears every stored field again
    task automatic tReset();
        wr(`FPU_CONTROL_STATUS_REG_FULL, 32'hffffffff);
        @(negedge clk);
        sysRst = 1'b1;
        @(negedge clk);
        sysRst = 1'b0;
        rdChk(`FPU_CONTROL_STATUS_REG_FULL, 32'h000c0000, "reset mid run");
        chk(trapReq, 1'b0, "reset no trap");
    endtask : tReset

    // ****************************************
    // Verdict and run control
    // ****************************************
    // Single place where the run ends
    task automatic endSim();
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : endSim

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        endSim();
    end

    // Main sequence, inputs moved on falling edges
    initial begin
        repeat (16) @(negedge clk);
        sysRst = 1'b0;
        @(negedge clk);
        tWide();
        tRound();
        tTrap();
        tResult();
        tCompare();
        tDenorm();
        tReset();
        endSim();
    end
endmodule : fpu_control_status_regs_test

`default_nettype wire
